// ### rtl/csb_pkg.sv
// Package for the shift, count and branch execution block.
// Assumes a 16-bit CPU with sixteen registers and byte-wide instructions.
package csb_pkg;

  localparam int          DATA_W      = 16;
  localparam int          OPC_MSB     = 7;
  localparam int          OPC_LSB     = 4;
  localparam int          SEL_MSB     = 3;
  localparam int          SEL_LSB     = 0;
  localparam logic [3:0]  REG_ACC     = 4'h1;
  localparam logic [3:0]  REG_FOUR    = 4'h4;
  localparam logic [3:0]  REG_INDEX   = 4'h5;
  localparam logic [3:0]  REG_SIX     = 4'h6;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] PC_STEP     = 16'h0001;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;
  localparam int          EXEC_CYCLES = 1;

  typedef enum logic [3:0] {
    OP_SHIFT_LEFT   = 4'h6,
    OP_SHIFT_RIGHT  = 4'h7,
    OP_INCREMENT    = 4'h8,
    OP_DECREMENT    = 4'h9,
    OP_COMPLEMENT   = 4'hA,
    OP_BRANCH_NNEG  = 4'hB,
    OP_BRANCH_NZERO = 4'hC,
    OP_READ_PORT    = 4'hD
  } csb_opcode_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] sel;
  } csb_instr_t;

  typedef struct packed {
    logic       valid;
    csb_instr_t instr;
  } csb_issue_t;

  typedef struct packed {
    logic       valid;
    csb_instr_t instr;
  } csb_pass_t;

endpackage

// ### rtl/csb_exec.sv
// Execution unit for shifts, increment, decrement, complement, index branches, port read.
// Assumes a fetch stage presents one instruction byte per cycle with a valid strobe,
// and the remaining instruction logic takes any opcode this unit passes on.
// Behaviour
// - Shift left moves the target up one place, drops bit 15 and fills bit 0 with zero.
// - Shifting register six left fills its bit 0 from the top bit of register four.
// - Shift right keeps bit 15, copies it into bit 14 and drops bit 0.
// - Increment adds one to the target and wraps from FFFFh to zero.
// - Decrement subtracts one from the target and wraps from zero to FFFFh.
// - Complement inverts every bit of the target.
// - Branch if nonnegative adds the selected register to the PC when index bit 15 is zero.
// - Branch if nonnegative steps the PC by one when index bit 15 is one.
// - Branch if nonzero adds the selected register to the PC when index is nonzero, else steps.
// - Each instruction takes one cycle; non-branching ones step the PC by one, opcodes passed on hold it.
// - The select field reaches any of the sixteen registers.
// - Only the target register (the accumulator for port read), the PC and the pass-on output change, and no flags exist.
// - Bits 7 to 4 are the opcode and bits 3 to 0 the register or port select.
// - Both branches test the index register at address 5h.
// - Port read copies all 16 bits of the selected port into the accumulator.
`timescale 1ns/10ps

module csb_exec
  import csb_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire csb_pkg::csb_issue_t issue,
  output logic [15:0]             port_sel_addr,
  input  wire logic [15:0]        port_rd_data,
  output csb_pkg::csb_pass_t      pass_out,
  output logic [15:0]             program_counter,
  input  wire logic [3:0]         dbg_sel,
  output logic [15:0]             dbg_data
);
  import csb_pkg::*;

  logic [15:0] regs_q [16];
  logic [15:0] regs_d [16];
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  csb_pass_t   pass_q;
  csb_pass_t   pass_d;

  logic [3:0]  opc;
  logic [3:0]  sel;
  logic [15:0] tgt;
  logic [15:0] idx;
  logic        wr_en;
  logic [3:0]  wr_sel;
  logic [15:0] wr_val;

  // Field split of the instruction byte
  // opcode and select
  assign opc = issue.instr.opcode;
  assign sel = issue.instr.sel;
  assign tgt = regs_q[sel];
  assign idx = regs_q[REG_INDEX];

  assign port_sel_addr = {12'h000, sel};

  always_comb begin
    wr_en  = 1'b0;
    wr_sel = sel;
    wr_val = tgt;
    pc_d   = pc_q;
    pass_d = '0;
    if (issue.valid) begin
      pc_d = pc_q + PC_STEP;
      case (opc)
        OP_SHIFT_LEFT: begin
          wr_en = 1'b1;
          wr_val = {tgt[14:0], 1'b0};
          if (sel == REG_SIX) begin
            wr_val = {tgt[14:0], regs_q[REG_FOUR][15]};
          end
        end
        OP_SHIFT_RIGHT: begin
          wr_en = 1'b1;
          wr_val = {tgt[15], tgt[15:1]};
        end
        OP_INCREMENT: begin
          wr_en = 1'b1;
          wr_val = tgt + 16'h0001;
        end
        OP_DECREMENT: begin
          wr_en = 1'b1;
          wr_val = tgt - 16'h0001;
        end
        OP_COMPLEMENT: begin
          wr_en = 1'b1;
          wr_val = ~tgt;
        end
        OP_BRANCH_NNEG: begin
          // taken when index bit 15 clear
          if (!idx[15]) begin
            pc_d = pc_q + tgt;
          end
        end
        OP_BRANCH_NZERO: begin
          if (idx != ZERO_WORD) begin
            pc_d = pc_q + tgt;
          end
        end
        OP_READ_PORT: begin
          wr_en  = 1'b1;
          wr_sel = REG_ACC;
          wr_val = port_rd_data;
        end
        default: begin
          pc_d         = pc_q;
          pass_d.valid = 1'b1;
          pass_d.instr = issue.instr;
        end
      endcase
    end
  end

  // only the register at wr_sel is written: the target, or the accumulator for port read
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_reg
      always_comb begin
        regs_d[gi] = regs_q[gi];
        if (wr_en && (wr_sel == 4'(gi))) begin
          regs_d[gi] = wr_val;
        end
      end
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          regs_q[gi] <= REG_RESET;
        end else begin
          regs_q[gi] <= regs_d[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_q   <= PC_RESET;
      pass_q <= '0;
    end else begin
      pc_q   <= pc_d;
      pass_q <= pass_d;
    end
  end

  assign program_counter = pc_q;
  assign pass_out        = pass_q;
  assign dbg_data        = regs_q[dbg_sel];

  // Assertions
  sequence s_issue(logic [3:0] op);
    issue.valid && opc == op;
  endsequence

  a_shift_left_zero: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_SHIFT_LEFT) ##0 sel != REG_SIX |=> regs_q[$past(sel)] == {$past(tgt[14:0]), 1'b0})
    else $error("shift left result wrong");

  a_shift_six_fill: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_SHIFT_LEFT) ##0 sel == REG_SIX
    |=> regs_q[REG_SIX][0] == $past(regs_q[REG_FOUR][15]) && $stable(regs_q[REG_FOUR]))
    else $error("register six fill wrong");

  a_shift_right_sign: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_SHIFT_RIGHT) |=> regs_q[$past(sel)] == {$past(tgt[15]), $past(tgt[15:1])})
    else $error("shift right result wrong");

  a_incr_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_INCREMENT) ##0 tgt == 16'hFFFF |=> regs_q[$past(sel)] == ZERO_WORD)
    else $error("increment wrap wrong");

  a_decr_value: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_DECREMENT) |=> regs_q[$past(sel)] == 16'($past(tgt) - 16'h0001))
    else $error("decrement result wrong");

  a_compl_value: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_COMPLEMENT) |=> regs_q[$past(sel)] == ~$past(tgt))
    else $error("complement result wrong");

  a_bnn_taken: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_BRANCH_NNEG) ##0 !idx[15] |=> pc_q == 16'($past(pc_q) + $past(tgt)))
    else $error("nonnegative branch not taken");

  a_bnn_fall: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_BRANCH_NNEG) ##0 idx[15] |=> pc_q == 16'($past(pc_q) + PC_STEP))
    else $error("nonnegative branch fall-through wrong");

  a_bnz_pc: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_BRANCH_NZERO) |=> pc_q == ($past(idx) != ZERO_WORD ?
      16'($past(pc_q) + $past(tgt)) : 16'($past(pc_q) + PC_STEP)))
    else $error("nonzero branch pc wrong");

  a_read_port_acc: assert property (@(posedge sys_clk) disable iff (reset)
    s_issue(OP_READ_PORT) |=> regs_q[REG_ACC] == $past(port_rd_data)
      && pc_q == 16'($past(pc_q) + PC_STEP))
    else $error("port read wrong");

  a_pass_other: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid && (opc < OP_SHIFT_LEFT || opc > OP_READ_PORT)
    |=> pass_q.valid && pass_q.instr == $past(issue.instr) && $stable(pc_q))
    else $error("unhandled opcode not passed on");

  a_idle_stable: assert property (@(posedge sys_clk) disable iff (reset)
    !issue.valid |=> $stable(pc_q) && $stable(regs_q[REG_INDEX]) && !pass_q.valid)
    else $error("state changed without an instruction");

endmodule

// ### verif/cpu_shift_count_branch_exec_test.sv
// Self-checking bench for the shift, count and branch execution unit.
// Assumes csb_pkg is compiled first; registers are seen through the debug readback.
`timescale 1ns/10ps

module cpu_shift_count_branch_exec_test;
  import csb_pkg::*;

  logic        sys_clk;
  logic        reset;
  csb_issue_t  issue;
  logic [15:0] port_sel_addr;
  logic [15:0] port_rd_data;
  csb_pass_t   pass_out;
  logic [15:0] program_counter;
  logic [3:0]  dbg_sel;
  logic [15:0] dbg_data;
  logic [15:0] pc_e;
  int          error_cnt;
  int          checks;
  int          cyc;

  csb_exec csb_exec_inst (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .issue           (issue),
    .port_sel_addr   (port_sel_addr),
    .port_rd_data    (port_rd_data),
    .pass_out        (pass_out),
    .program_counter (program_counter),
    .dbg_sel         (dbg_sel),
    .dbg_data        (dbg_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Idle cycle first, so the strobe is never raised in the step that lowered it
  task automatic exec(input logic [3:0] op, input logic [3:0] sel, input logic [15:0] delta);
    @(negedge sys_clk);
    issue = '{valid: 1'b1, instr: '{opcode: op, sel: sel}};
    @(posedge sys_clk);
    @(negedge sys_clk);
    issue.valid = 1'b0;
    pc_e = pc_e + delta;
    cmp(program_counter, pc_e, "program counter");
  endtask

  task automatic reg_is(input logic [3:0] r, input logic [15:0] exp);
    dbg_sel = r;
    #1;
    cmp(dbg_data, exp, "register");
    @(negedge sys_clk);
  endtask

  task automatic load_acc(input logic [15:0] val);
    port_rd_data = val;
    exec(4'hD, 4'h7, 16'h0001);
    cmp(port_sel_addr, 16'h0007, "port address");
    port_rd_data = ~val;
    reg_is(4'h1, val);
  endtask

  task automatic t_count;
    for (int r = 0; r < 16; r++) begin
      reg_is(4'(r), 16'h0000);
      exec(4'h8, 4'(r), 16'h0001);
      reg_is(4'(r), 16'h0001);
      reg_is(4'(r + 1), 16'h0000);
      exec(4'h9, 4'(r), 16'h0001);
      reg_is(4'(r), 16'h0000);
    end
    exec(4'h9, 4'h3, 16'h0001);
    reg_is(4'h3, 16'hFFFF);
    exec(4'h8, 4'h3, 16'h0001);
    reg_is(4'h3, 16'h0000);
    $display("t_count done");
  endtask

  task automatic t_shift;
    load_acc(16'h8001);
    exec(4'h7, 4'h1, 16'h0001);
    reg_is(4'h1, 16'hC000);
    exec(4'h6, 4'h1, 16'h0001);
    reg_is(4'h1, 16'h8000);
    exec(4'hA, 4'h1, 16'h0001);
    reg_is(4'h1, 16'h7FFF);
    exec(4'hA, 4'h4, 16'h0001);
    exec(4'h6, 4'h6, 16'h0001);
    reg_is(4'h6, 16'h0001);
    reg_is(4'h4, 16'hFFFF);
    // Zero fill must hold even while register four has its top bit set
    exec(4'h6, 4'h1, 16'h0001);
    reg_is(4'h1, 16'hFFFE);
    exec(4'hA, 4'h4, 16'h0001);
    exec(4'h6, 4'h6, 16'h0001);
    reg_is(4'h6, 16'h0002);
    $display("t_shift done");
  endtask

  task automatic t_branch;
    load_acc(16'h0010);
    exec(4'hC, 4'h1, 16'h0001);
    exec(4'hB, 4'h1, 16'h0010);
    exec(4'h8, 4'h5, 16'h0001);
    exec(4'hC, 4'h1, 16'h0010);
    exec(4'hA, 4'h5, 16'h0001);
    exec(4'hB, 4'h1, 16'h0001);
    load_acc(16'hFFF0);
    exec(4'hC, 4'h1, 16'hFFF0);
    $display("t_branch done");
  endtask

  task automatic t_pass;
    exec(4'h2, 4'h1, 16'h0000);
    cmp({7'h00, pass_out}, {7'h00, 1'b1, 8'h21}, "pass on");
    @(negedge sys_clk);
    cmp({15'h0000, pass_out.valid}, 16'h0000, "pass pulse");
    reg_is(4'h1, 16'hFFF0);
    $display("t_pass done");
  endtask

  task automatic wrap_up;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("FAIL %0t run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    reset = 1'b1;
    issue = '0;
    port_rd_data = 16'h0000;
    dbg_sel = 4'h0;
    pc_e = 16'h0000;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    cmp(program_counter, 16'h0000, "reset pc");
    t_count();
    t_shift();
    t_branch();
    t_pass();
    wrap_up();
  end
endmodule
